// ### logic/cbsu_pkg.sv
package cbsu_pkg;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam logic [2:0] CBSU_FLAG_C = 3'h0;
  localparam logic [2:0] CBSU_FLAG_Z = 3'h1;
  localparam logic [2:0] CBSU_FLAG_N = 3'h2;

  // ----------------------------------------------------------------
  // Cycle counts, PC steps and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CBSU_CYC_SEQ   = 2'h1;
  localparam logic [1:0] CBSU_CYC_BR    = 2'h2;
  localparam logic [1:0] CBSU_CYC_SKIP1 = 2'h2;
  localparam logic [1:0] CBSU_CYC_SKIP2 = 2'h3;
  localparam logic [1:0] CBSU_STEP_SEQ  = 2'h1;
  localparam logic [1:0] CBSU_STEP_SK1  = 2'h2;
  localparam logic [1:0] CBSU_STEP_SK2  = 2'h3;
  localparam logic [1:0] CBSU_CNT_RST   = 2'h0;
  localparam logic [7:0] CBSU_STAT_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CBSU_SKIP_ON_REG_BIT_LOW  = 4'h0,
    CBSU_SKIP_ON_REG_BIT_HIGH = 4'h1,
    CBSU_SKIP_ON_IO_BIT_LOW   = 4'h2,
    CBSU_SKIP_ON_IO_BIT_HIGH  = 4'h3,
    CBSU_BRANCH_ON_FLAG_HIGH  = 4'h4,
    CBSU_BRANCH_ON_FLAG_LOW   = 4'h5,
    CBSU_BRANCH_IF_EQUAL      = 4'h6,
    CBSU_BRANCH_IF_NOT_EQUAL  = 4'h7,
    CBSU_BRANCH_ON_CARRY_HIGH = 4'h8,
    CBSU_BRANCH_ON_CARRY_LOW  = 4'h9,
    CBSU_BRANCH_SAME_OR_HIGHER = 4'hA,
    CBSU_BRANCH_IF_LOWER      = 4'hB,
    CBSU_BRANCH_IF_MINUS      = 4'hC,
    CBSU_BRANCH_IF_PLUS       = 4'hD
  } cbsu_op_t;

  typedef enum logic [0:0] {
    CBSU_IDLE = 1'b0,
    CBSU_WAIT = 1'b1
  } cbsu_state_t;

endpackage : cbsu_pkg

// ### logic/cbsu_unit.sv
`timescale 1ns/1ps
module cbsu_unit
  import cbsu_pkg::*;
#(
  parameter int PC_W  = 16,
  parameter int OFS_W = 7
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Request from decode
  input  wire logic                    start,
  input  wire cbsu_op_t                op,
  input  wire logic [2:0]              bit_sel,
  input  wire logic [7:0]              reg_val,
  input  wire logic [7:0]              io_val,
  input  wire logic [7:0]              status_in,
  input  wire logic [OFS_W-1:0]        offset,
  input  wire logic                    next_two_word,
  input  wire logic [PC_W-1:0]         pc_in,
  // Answer to fetch and PC logic
  output logic                         ready,
  output logic                         done,
  output logic                         taken,
  output logic [PC_W-1:0]              pc_out,
  output logic [7:0]                   status_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (OFS_W < 2 || PC_W <= OFS_W) begin : g_bad_width
    $error("cbsu_unit: PC_W must exceed OFS_W and OFS_W must be at least 2");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [PC_W-1:0] ofs_ext(input logic [OFS_W-1:0] k);
    ofs_ext = {{(PC_W-OFS_W){k[OFS_W-1]}}, k};
  endfunction : ofs_ext

  function automatic logic is_skip(input cbsu_op_t o);
    is_skip = (o == CBSU_SKIP_ON_REG_BIT_LOW) || (o == CBSU_SKIP_ON_REG_BIT_HIGH) ||
              (o == CBSU_SKIP_ON_IO_BIT_LOW) || (o == CBSU_SKIP_ON_IO_BIT_HIGH);
  endfunction : is_skip

  logic cond_c;

  always_comb begin
    cond_c = 1'b0;
    unique case (op)
      CBSU_SKIP_ON_REG_BIT_LOW:   cond_c = ~reg_val[bit_sel];
      CBSU_SKIP_ON_REG_BIT_HIGH:  cond_c = reg_val[bit_sel];
      CBSU_SKIP_ON_IO_BIT_LOW:    cond_c = ~io_val[bit_sel];
      CBSU_SKIP_ON_IO_BIT_HIGH:   cond_c = io_val[bit_sel];
      CBSU_BRANCH_ON_FLAG_HIGH:   cond_c = status_in[bit_sel];
      CBSU_BRANCH_ON_FLAG_LOW:    cond_c = ~status_in[bit_sel];
      CBSU_BRANCH_IF_EQUAL:       cond_c = status_in[CBSU_FLAG_Z];
      CBSU_BRANCH_IF_NOT_EQUAL:   cond_c = ~status_in[CBSU_FLAG_Z];
      CBSU_BRANCH_ON_CARRY_HIGH,
      CBSU_BRANCH_IF_LOWER:       cond_c = status_in[CBSU_FLAG_C];
      CBSU_BRANCH_ON_CARRY_LOW,
      CBSU_BRANCH_SAME_OR_HIGHER: cond_c = ~status_in[CBSU_FLAG_C];
      CBSU_BRANCH_IF_MINUS:       cond_c = status_in[CBSU_FLAG_N];
      CBSU_BRANCH_IF_PLUS:        cond_c = ~status_in[CBSU_FLAG_N];
      // Unused codes fall through as untaken, one cycle
      default:                    cond_c = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  cbsu_state_t     state_r, state_nxt;
  logic [1:0]      cnt_r, cnt_nxt;
  logic            ready_r, ready_nxt;
  logic            done_r, done_nxt;
  logic            taken_r, taken_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0]      status_r, status_nxt;
  logic [1:0]      len_c;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    done_nxt   = 1'b0;
    taken_nxt  = taken_r;
    pc_nxt     = pc_r;
    status_nxt = status_r;
    len_c      = CBSU_CYC_SEQ;
    unique case (state_r)
      CBSU_IDLE: begin
        // Ready is still low on the first edge after reset: refuse there too
        if (start && ready_r) begin
          taken_nxt  = cond_c;
          // Flags are only passed through, never altered
          status_nxt = status_in;
          if (!cond_c) begin
            len_c  = CBSU_CYC_SEQ;
            pc_nxt = pc_in + PC_W'(CBSU_STEP_SEQ);
          end else if (is_skip(op)) begin
            len_c  = next_two_word ? CBSU_CYC_SKIP2 : CBSU_CYC_SKIP1;
            pc_nxt = pc_in + PC_W'(next_two_word ? CBSU_STEP_SK2
                                                 : CBSU_STEP_SK1);
          end else begin
            len_c  = CBSU_CYC_BR;
            pc_nxt = pc_in + ofs_ext(offset) + PC_W'(CBSU_STEP_SEQ);
          end
          if (len_c == CBSU_CYC_SEQ) begin
            done_nxt = 1'b1;
          end else begin
            cnt_nxt   = len_c - 2'h1;
            state_nxt = CBSU_WAIT;
          end
        end
      end
      CBSU_WAIT: begin
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == 2'h1) begin
          done_nxt  = 1'b1;
          state_nxt = CBSU_IDLE;
        end
      end
    endcase
    ready_nxt = (state_nxt == CBSU_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r  <= CBSU_IDLE;
      cnt_r    <= CBSU_CNT_RST;
      ready_r  <= 1'b0;
      done_r   <= 1'b0;
      taken_r  <= 1'b0;
      pc_r     <= '0;
      status_r <= CBSU_STAT_RST;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      ready_r  <= ready_nxt;
      done_r   <= done_nxt;
      taken_r  <= taken_nxt;
      pc_r     <= pc_nxt;
      status_r <= status_nxt;
    end
  end

  assign ready      = ready_r;
  assign done       = done_r;
  assign taken      = taken_r;
  assign pc_out     = pc_r;
  assign status_out = status_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic acc_c;
  assign acc_c = start && ready_r;

  sequence s_one;
    ##1 done_r && !taken_r && pc_r == $past(pc_in) + PC_W'(CBSU_STEP_SEQ);
  endsequence

  sequence s_skip1;
    ##1 !done_r ##1 done_r && taken_r && pc_r == $past(pc_in, 2) + PC_W'(CBSU_STEP_SK1);
  endsequence

  sequence s_skip2;
    ##1 !done_r [*2] ##1 done_r && taken_r &&
      pc_r == $past(pc_in, 3) + PC_W'(CBSU_STEP_SK2);
  endsequence

  sequence s_branch;
    ##1 !done_r ##1 done_r && taken_r &&
      pc_r == $past(pc_in, 2) + ofs_ext($past(offset, 2)) + PC_W'(CBSU_STEP_SEQ);
  endsequence

  AST_REG_LOW: assert property (
    acc_c && op == CBSU_SKIP_ON_REG_BIT_LOW && !next_two_word && !reg_val[bit_sel]
    |-> s_skip1) else $error("reg-low skip wrong");
  AST_REG_HIGH: assert property (
    acc_c && op == CBSU_SKIP_ON_REG_BIT_HIGH && next_two_word && reg_val[bit_sel]
    |-> s_skip2) else $error("reg-high skip wrong");
  AST_REG_HIGH_ONE: assert property (
    acc_c && op == CBSU_SKIP_ON_REG_BIT_HIGH && !next_two_word && reg_val[bit_sel]
    |-> s_skip1) else $error("reg-high one-word skip wrong");
  AST_IO_LOW: assert property (
    acc_c && op == CBSU_SKIP_ON_IO_BIT_LOW && io_val[bit_sel]
    |-> s_one) else $error("io-low no-skip wrong");
  AST_IO_LOW_SKIP: assert property (
    acc_c && op == CBSU_SKIP_ON_IO_BIT_LOW && !next_two_word && !io_val[bit_sel]
    |-> s_skip1) else $error("io-low skip wrong");
  AST_IO_HIGH: assert property (
    acc_c && op == CBSU_SKIP_ON_IO_BIT_HIGH && !next_two_word && io_val[bit_sel]
    |-> s_skip1) else $error("io-high skip wrong");
  AST_IO_HIGH_TWO: assert property (
    acc_c && op == CBSU_SKIP_ON_IO_BIT_HIGH && next_two_word && io_val[bit_sel]
    |-> s_skip2) else $error("io-high two-word skip wrong");
  AST_FLAG_HIGH: assert property (
    acc_c && op == CBSU_BRANCH_ON_FLAG_HIGH && status_in[bit_sel]
    |-> s_branch) else $error("flag branch wrong");
  AST_FLAG_LOW: assert property (
    acc_c && op == CBSU_BRANCH_ON_FLAG_LOW && status_in[bit_sel]
    |-> s_one) else $error("flag-low taken wrongly");
  AST_EQUAL: assert property (
    acc_c && op == CBSU_BRANCH_IF_EQUAL && status_in[CBSU_FLAG_Z]
    |-> s_branch) else $error("equal branch wrong");
  AST_EQUAL_MISS: assert property (
    acc_c && op == CBSU_BRANCH_IF_EQUAL && !status_in[CBSU_FLAG_Z]
    |-> s_one) else $error("equal taken wrongly");
  AST_NOT_EQUAL: assert property (
    acc_c && op == CBSU_BRANCH_IF_NOT_EQUAL && !status_in[CBSU_FLAG_Z]
    |-> s_branch) else $error("ne branch wrong");
  AST_CARRY_HIGH: assert property (
    acc_c && op == CBSU_BRANCH_ON_CARRY_HIGH && status_in[CBSU_FLAG_C]
    |-> s_branch) else $error("carry-high branch wrong");
  AST_LOWER: assert property (
    acc_c && op == CBSU_BRANCH_IF_LOWER && !status_in[CBSU_FLAG_C]
    |-> s_one) else $error("lower taken wrongly");
  AST_SAME_HIGH: assert property (
    acc_c && op == CBSU_BRANCH_SAME_OR_HIGHER && !status_in[CBSU_FLAG_C]
    |-> s_branch) else $error("sh branch wrong");
  AST_MINUS: assert property (
    acc_c && op == CBSU_BRANCH_IF_MINUS && status_in[CBSU_FLAG_N]
    |-> s_branch) else $error("minus branch wrong");
  AST_PLUS: assert property (
    acc_c && op == CBSU_BRANCH_IF_PLUS && status_in[CBSU_FLAG_N]
    |-> s_one) else $error("plus taken wrongly");
  AST_FLAGS: assert property (
    acc_c |-> ##1 status_r == $past(status_in))
    else $error("status flags altered");
  AST_NOT_TAKEN: assert property (
    acc_c && !cond_c |-> s_one)
    else $error("untaken not one cycle");
  // Idle but not yet ready only on the first edge after reset
  AST_REFUSE: assert property (
    start && !ready_r && state_r == CBSU_IDLE |=> state_r == CBSU_IDLE && !done_r)
    else $error("request taken while not ready");

endmodule : cbsu_unit

// ### verification/cbsu_fetch_model.sv
`timescale 1ns/1ps
module cbsu_fetch_model
  import cbsu_pkg::*;
(
  // Clock and answer
  input  wire logic   clk,
  input  wire logic   ready,
  input  wire logic   done,
  // Request to the unit
  output logic        start,
  output cbsu_op_t    op,
  output logic [2:0]  bit_sel,
  output logic [7:0]  reg_val,
  output logic [7:0]  io_val,
  output logic [7:0]  status_in,
  output logic [6:0]  offset,
  output logic        next_two_word,
  output logic [15:0] pc_in
);
  initial begin
    start = 1'b0;
    op = CBSU_BRANCH_IF_PLUS;
    {bit_sel, reg_val, io_val, status_in, offset, next_two_word, pc_in} = '0;
  end

  // --------------------------------------------------------------
  // Issue one request, return cycles from accept to done
  // --------------------------------------------------------------
  task automatic issue(input cbsu_op_t o, input logic [2:0] b, input logic [7:0] v,
                       input logic two, input logic [6:0] k, input logic [15:0] pc,
                       output int cyc);
    @(negedge clk);
    start = 1'b1;
    op = o;
    bit_sel = b;
    {reg_val, io_val, status_in} = {v, v, v};
    offset = k;
    next_two_word = two;
    pc_in = pc;
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    // Inputs are dead after accept: show garbage, not the old value
    start = 1'b0;
    op = cbsu_op_t'(~o);
    bit_sel = ~b;
    {reg_val, io_val, status_in} = {~v, ~v, ~v};
    offset = ~k;
    next_two_word = ~two;
    pc_in = ~pc;
    cyc = 1;
    while (done !== 1'b1 && cyc < 8) begin
      @(negedge clk);
      cyc++;
    end
  endtask : issue
endmodule : cbsu_fetch_model

// ### verification/cbsu_unit_test.sv
`timescale 1ns/1ps
module cbsu_unit_test
  import cbsu_pkg::*;
;
  logic clk, reset_n, start, next_two_word, ready, done, taken;
  logic [2:0] bit_sel;
  logic [7:0] reg_val, io_val, status_in, status_out;
  logic [6:0] offset;
  logic [15:0] pc_in, pc_out;
  cbsu_op_t op;
  int failures = 0;
  int checks = 0;

  cbsu_unit dut (.clk(clk), .reset_n(reset_n), .start(start), .op(op), .bit_sel(bit_sel),
    .reg_val(reg_val), .io_val(io_val), .status_in(status_in), .offset(offset),
    .next_two_word(next_two_word), .pc_in(pc_in), .ready(ready), .done(done),
    .taken(taken), .pc_out(pc_out), .status_out(status_out));
  cbsu_fetch_model fetch (.clk(clk), .ready(ready), .done(done), .start(start), .op(op),
    .bit_sel(bit_sel), .reg_val(reg_val), .io_val(io_val), .status_in(status_in),
    .offset(offset), .next_two_word(next_two_word), .pc_in(pc_in));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // One request against the expected outcome
  // ----------------------------------------------------------------
  task automatic run(input cbsu_op_t o, input logic [2:0] b, input logic [7:0] v,
                     input logic two, input logic [6:0] k, input logic [15:0] pc);
    logic c;
    int cyc;
    logic [15:0] step;
    case (o)
      CBSU_SKIP_ON_REG_BIT_LOW, CBSU_SKIP_ON_IO_BIT_LOW: c = !v[b];
      CBSU_SKIP_ON_REG_BIT_HIGH, CBSU_SKIP_ON_IO_BIT_HIGH: c = v[b];
      CBSU_BRANCH_ON_FLAG_HIGH: c = v[b];
      CBSU_BRANCH_ON_FLAG_LOW: c = !v[b];
      CBSU_BRANCH_IF_EQUAL: c = v[CBSU_FLAG_Z];
      CBSU_BRANCH_IF_NOT_EQUAL: c = !v[CBSU_FLAG_Z];
      CBSU_BRANCH_ON_CARRY_HIGH, CBSU_BRANCH_IF_LOWER: c = v[CBSU_FLAG_C];
      CBSU_BRANCH_ON_CARRY_LOW, CBSU_BRANCH_SAME_OR_HIGHER: c = !v[CBSU_FLAG_C];
      CBSU_BRANCH_IF_MINUS: c = v[CBSU_FLAG_N];
      CBSU_BRANCH_IF_PLUS: c = !v[CBSU_FLAG_N];
      default: c = 1'b0;
    endcase
    // Skips move past one or two words, branches by the signed offset
    if (o < CBSU_BRANCH_ON_FLAG_HIGH) step = c ? (two ? 16'h0003 : 16'h0002) : 16'h0001;
    else step = c ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001;
    fetch.issue(o, b, v, two, k, pc, cyc);
    check({15'h0000, taken}, {15'h0000, c}, "taken");
    check(pc_out, pc + step, "next pc");
    check(16'(cyc), (o < CBSU_BRANCH_ON_FLAG_HIGH && c) ? (two ? 16'h0003 : 16'h0002)
          : (c ? 16'h0002 : 16'h0001), "cycles");
    check({8'h00, status_out}, {8'h00, v}, "flags");
    check({15'h0000, ready}, 16'h0001, "ready at done");
  endtask : run

  task automatic test_skips;
    for (int o = 0; o < 4; o++)
      for (int b = 0; b < 8; b++) run(cbsu_op_t'(o), 3'(b), 8'hA5, b[1], 7'h00, 16'h0100);
    $display("test_skips done");
  endtask : test_skips

  task automatic test_branches;
    logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'h05, 8'hFA};
    for (int o = 4; o < 16; o++)
      for (int i = 0; i < 4; i++) begin
        run(cbsu_op_t'(o), 3'(i * 3), vals[i], 1'b0, 7'h7D, 16'h0001);
        run(cbsu_op_t'(o), 3'(i * 3 + 1), vals[i], 1'b1, 7'h3F, 16'hFFF0);
      end
    $display("test_branches done");
  endtask : test_branches

  task automatic test_reset;
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    check({13'h0000, ready, done, taken}, 16'h0000, "reset outputs");
    check(pc_out, 16'h0000, "reset pc");
    check({8'h00, status_out}, 16'h0000, "reset status");
    fork begin
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
    end join_none
    // Request stands from inside reset across the first edge, where ready is low
    run(CBSU_BRANCH_IF_EQUAL, 3'h0, 8'h02, 1'b0, 7'h10, 16'h0200);
    $display("test_reset done");
  endtask : test_reset

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    test_skips();
    test_branches();
    test_reset();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : cbsu_unit_test
